// [hdl/keyed_watchdog_timer.sv]
// Purpose: watchdog with keyed register writes, /128 prescaler and 8-bit reload counter
// Assumes: oscillator inputs are slow levels synchronous to CLOCK; one access per cycle
// Notes:   count sources are edge-detected in the CLOCK domain, so each must run below
//          half the CLOCK rate; the bus-clock source counts every CLOCK edge
`timescale 1ns/1ps
`include "keyed_watchdog_cfg.svh"

// How it works
// - divide by 128, then decrement 8-bit counter
// - timeout spans 128 to 128x256 periods
// - enabling loads reload constant then counts
// - reset mode: underflow requests processor reset
// - feed pattern write reloads the counter
// - writes need key; key reads zero
// - mode bit picks reset or interrupt
// - interrupt only when flag and mode set
// - interrupt mode sets flag; zero clears
// - reset-mode underflow also clears the flag
// - two-bit select picks one of four sources
// - reload constant resets 0xff, n gives n+1
// - register access and counting run independently
// - feed field write-only, reads zero
// - timeout whenever enabled and source running
module keyed_watchdog_timer
   import keyed_watchdog_pkg::*;
#(
   parameter int PRE_W = 7,                       // prescaler width, 2**PRE_W divide
   parameter int CNT_W = 8                        // watchdog counter width
) (
   input  wire logic                        CLOCK,       // system clock
   input  wire logic                        RST_N,       // synchronous reset, active low
   input  wire keyed_watchdog_pkg::reg_req_s REG_REQ,    // register access
   output logic [31:0]                      REG_RDATA,   // read data, one cycle after rd
   input  wire logic                        FAST_OSC,    // internal fast oscillator level
   input  wire logic                        SLOW_OSC,    // internal slow oscillator level
   input  wire logic                        SLOW_XTAL,   // external slow crystal level
   output logic                             RESET_REQ,   // one-cycle system reset request
   output logic                             TIMEOUT_IRQ  // level interrupt request
);
   import keyed_watchdog_pkg::*;

   logic                run_en_q;
   logic                irq_mode_q;
   logic                flag_q;
   count_clock_select_e clk_sel_q;
   logic [CNT_W-1:0]    reload_q;
   logic [PRE_W-1:0]    pre_q;
   logic [CNT_W-1:0]    cnt_q;
   logic [2:0]          src_prev_q;
   logic                reset_req_q;
   logic [31:0]         rdata_q;

   logic                key_ok;
   logic                wr_config;
   logic                wr_clksrc;
   logic                wr_const;
   logic                feed;
   logic                start;
   logic [2:0]          src_now;
   logic [2:0]          src_rise;
   logic                src_tick;
   logic                pre_tick;
   logic                timeout;
   logic [31:0]         rd_mux;

   // unkeyed writes are dropped whole, never partially applied
   assign key_ok    = REG_REQ.wr &&
                      (REG_REQ.wdata[`WDT_KEY_HI:`WDT_KEY_LO] == `WDT_KEY_VALUE);
   assign wr_config = key_ok && (REG_REQ.addr == `WDT_OFF_CONFIG);
   assign wr_clksrc = key_ok && (REG_REQ.addr == `WDT_OFF_CLKSRC);
   assign wr_const  = key_ok && (REG_REQ.addr == `WDT_OFF_CONST);
   assign feed      = key_ok && (REG_REQ.addr == `WDT_OFF_FEED) &&
                      (REG_REQ.wdata[`WATCHDOG_FEED_HI:`WATCHDOG_FEED_LO] == `WATCHDOG_FEED_VALUE);
   assign start     = wr_config && REG_REQ.wdata[`WDT_EN_BIT] && !run_en_q;

   // configuration registers
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         run_en_q   <= 1'b0;
         irq_mode_q <= 1'b0;
      end else if (wr_config) begin
         run_en_q   <= REG_REQ.wdata[`WDT_EN_BIT];
         irq_mode_q <= REG_REQ.wdata[`WDT_IRQ_MODE_BIT];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         clk_sel_q <= count_clock_select_e'(`WDT_SEL_RESET);
      end else if (wr_clksrc) begin
         clk_sel_q <= count_clock_select_e'(REG_REQ.wdata[`WDT_SEL_HI:`WDT_SEL_LO]);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         reload_q <= `WDT_CONST_RESET;
      end else if (wr_const) begin
         reload_q <= REG_REQ.wdata[`WDT_CONST_HI:`WDT_CONST_LO];
      end
   end

   // count source selection; edges of the three oscillator sources become single-cycle ticks
   assign src_now  = {SLOW_XTAL, SLOW_OSC, FAST_OSC};
   assign src_rise = src_now & ~src_prev_q;

   // seeded from the pins during reset, so a source already high is not taken as an edge
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         src_prev_q <= src_now;
      end else begin
         src_prev_q <= src_now;
      end
   end

   always_comb begin
      unique case (clk_sel_q)
         SRC_FAST_OSC:  src_tick = src_rise[0];
         SRC_BUS_CLOCK: src_tick = 1'b1;
         SRC_SLOW_OSC:  src_tick = src_rise[1];
         SRC_SLOW_XTAL: src_tick = src_rise[2];
      endcase
   end

   assign pre_tick = run_en_q && src_tick && (pre_q == '1);
   // the counter is already at zero when the last tick arrives: reload n gives n+1 ticks
   assign timeout  = pre_tick && (cnt_q == '0) && !feed;

   // prescaler and down counter; feed also clears the prescaler so every feed buys the
   // full interval instead of a fraction of a prescaler period less
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         pre_q <= '0;
         cnt_q <= `WDT_CONST_RESET;
      end else if (start || feed) begin
         pre_q <= '0;
         cnt_q <= reload_q;
      end else if (!run_en_q) begin
         pre_q <= '0;
      end else if (src_tick) begin
         pre_q <= pre_q + PRE_W'(1);
         if (pre_q == '1) begin
            cnt_q <= (cnt_q == '0) ? reload_q : cnt_q - CNT_W'(1);
         end
      end
   end

   // timeout action
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         reset_req_q <= 1'b0;
      end else begin
         reset_req_q <= timeout && !irq_mode_q;
      end
   end

   // an interrupt-mode timeout in the same cycle as a software clear keeps the flag set
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         flag_q <= 1'b0;
      end else if (timeout && irq_mode_q) begin
         flag_q <= 1'b1;
      end else if (timeout) begin
         flag_q <= 1'b0;
      end else if (wr_config && !REG_REQ.wdata[`WDT_FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // read side; key and feed fields never return data
   always_comb begin
      rd_mux = `WDT_ZERO_WORD;
      unique case (REG_REQ.addr)
         `WDT_OFF_CONFIG: begin
            rd_mux[`WDT_EN_BIT]       = run_en_q;
            rd_mux[`WDT_IRQ_MODE_BIT] = irq_mode_q;
            rd_mux[`WDT_FLAG_BIT]     = flag_q;
         end
         `WDT_OFF_CLKSRC: rd_mux[`WDT_SEL_HI:`WDT_SEL_LO] = clk_sel_q;
         `WDT_OFF_CONST:  rd_mux[`WDT_CONST_HI:`WDT_CONST_LO] = reload_q;
         default:         rd_mux = `WDT_ZERO_WORD;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         rdata_q <= `WDT_ZERO_WORD;
      end else if (REG_REQ.rd) begin
         rdata_q <= rd_mux;
      end
   end

   assign REG_RDATA   = rdata_q;
   assign RESET_REQ   = reset_req_q;
   assign TIMEOUT_IRQ = flag_q && irq_mode_q;

   // checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   property p_bad_key;
      REG_REQ.wr && (REG_REQ.wdata[`WDT_KEY_HI:`WDT_KEY_LO] != `WDT_KEY_VALUE)
      |=> $stable(reload_q) && $stable(run_en_q) && $stable(clk_sel_q);
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("unkeyed write changed a register");

   property p_feed;
      feed |=> (cnt_q == $past(reload_q)) && (pre_q == '0);
   endproperty
   a_feed: assert property (p_feed) else $error("feed did not reload the counter");

   property p_bad_feed;
      key_ok && (REG_REQ.addr == `WDT_OFF_FEED) && !feed && !pre_tick
      |=> $stable(cnt_q);
   endproperty
   a_bad_feed: assert property (p_bad_feed) else $error("wrong feed value moved counter");

   property p_start;
      start |=> run_en_q && (cnt_q == $past(reload_q)) && (pre_q == '0);
   endproperty
   a_start: assert property (p_start) else $error("enable did not load the constant");

   property p_prescale;
      run_en_q && src_tick && !feed && !start && (pre_q != '1)
      |=> (pre_q == $past(pre_q) + PRE_W'(1)) && $stable(cnt_q);
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler step wrong");

   property p_decrement;
      pre_tick && !feed && (cnt_q != '0) |=> cnt_q == $past(cnt_q) - CNT_W'(1);
   endproperty
   a_decrement: assert property (p_decrement) else $error("counter did not decrement");

   property p_reset_mode;
      timeout && !irq_mode_q |=> RESET_REQ && !flag_q ##1 !RESET_REQ;
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("reset mode timeout wrong");

   property p_irq_mode;
      timeout && irq_mode_q |=> flag_q && TIMEOUT_IRQ && !RESET_REQ;
   endproperty
   a_irq_mode: assert property (p_irq_mode) else $error("interrupt mode timeout wrong");

   property p_irq_gate;
      TIMEOUT_IRQ |-> irq_mode_q && ($past(timeout) || $past(flag_q));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without mode bit");

   property p_flag_clear;
      wr_config && !REG_REQ.wdata[`WDT_FLAG_BIT] && !timeout |=> !flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by zero");

   property p_read_zero;
      REG_REQ.rd |=> (REG_RDATA[`WDT_KEY_HI:`WDT_KEY_LO] == 16'h0000) &&
                     (($past(REG_REQ.addr) != `WDT_OFF_FEED) || (REG_RDATA == `WDT_ZERO_WORD));
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("key or feed read not zero");

   property p_bus_source;
      run_en_q && (clk_sel_q == SRC_BUS_CLOCK) && !feed && !start
      |=> pre_q == $past(pre_q) + PRE_W'(1);
   endproperty
   a_bus_source: assert property (p_bus_source) else $error("bus clock source not ticking");

   property p_const_reset;
      $rose(RST_N) |-> (reload_q == `WDT_CONST_RESET) && !run_en_q;
   endproperty
   a_const_reset: assert property (p_const_reset) else $error("reset values wrong");

   property p_reset_only;
      RESET_REQ |-> $past(timeout) && !$past(irq_mode_q);
   endproperty
   a_reset_only: assert property (p_reset_only) else $error("stray reset request");

   property p_idle_hold;
      !run_en_q && !start && !feed |=> (pre_q == '0) && $stable(cnt_q);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle counter moved");

   property p_wrap_reload;
      timeout |=> cnt_q == $past(reload_q);
   endproperty
   a_wrap_reload: assert property (p_wrap_reload) else $error("no reload on timeout");

   property p_src_write;
      wr_clksrc |=> clk_sel_q == $past(REG_REQ.wdata[`WDT_SEL_HI:`WDT_SEL_LO]);
   endproperty
   a_src_write: assert property (p_src_write) else $error("select not written");

   property p_const_write;
      wr_const |=> reload_q == $past(REG_REQ.wdata[`WDT_CONST_HI:`WDT_CONST_LO]);
   endproperty
   a_const_write: assert property (p_const_write) else $error("constant lost");

   c_irq_timeout:   cover property (timeout && irq_mode_q);
   c_reset_timeout: cover property (timeout && !irq_mode_q);
   c_feed_running:  cover property (feed && run_en_q);
   c_flag_cleared:  cover property (flag_q ##1 !flag_q);
   c_unkeyed_write: cover property (REG_REQ.wr && !key_ok);

endmodule

// [pkg/keyed_watchdog_cfg.svh]
// Purpose: register offsets, field positions, key values and reset values of the watchdog
// Assumes: byte offsets on a 4-bit register address
// Notes:   included by the design file and by the bench
`ifndef KEYED_WATCHDOG_CFG_SVH
`define KEYED_WATCHDOG_CFG_SVH

`define WDT_OFF_CONFIG      4'h0
`define WDT_OFF_CLKSRC      4'h4
`define WDT_OFF_CONST       4'h8
`define WDT_OFF_FEED        4'hc

`define WDT_KEY_HI          31
`define WDT_KEY_LO          16
`define WDT_KEY_VALUE       16'h5afa
`define WATCHDOG_FEED_HI         15
`define WATCHDOG_FEED_LO         0
`define WATCHDOG_FEED_VALUE      16'h55aa

`define WDT_EN_BIT          0
`define WDT_IRQ_MODE_BIT    1
`define WDT_FLAG_BIT        2
`define WDT_SEL_HI          1
`define WDT_SEL_LO          0
`define WDT_CONST_HI        7
`define WDT_CONST_LO        0

`define WDT_CONST_RESET     8'hff
`define WDT_SEL_RESET       2'h0
`define WDT_ZERO_WORD       32'h0000_0000

`endif

// [pkg/keyed_watchdog_pkg.sv]
// Purpose: shared types of the keyed watchdog
// Assumes: 32-bit register data, byte offsets on 4 address bits
// Notes:   constants live in keyed_watchdog_cfg.svh
package keyed_watchdog_pkg;

   // one register access, taken in a single CLOCK cycle
   typedef struct packed {
      logic        wr;     // write strobe
      logic        rd;     // read strobe
      logic [3:0]  addr;   // byte offset
      logic [31:0] wdata;  // write data, key in the top half
   } reg_req_s;

   typedef enum logic [1:0] {
      SRC_FAST_OSC  = 2'h0,
      SRC_BUS_CLOCK = 2'h1,
      SRC_SLOW_OSC  = 2'h2,
      SRC_SLOW_XTAL = 2'h3
   } count_clock_select_e;

endpackage

// [bench/osc_model.sv]
// Purpose: oscillator sources feeding the count clock select
// Assumes: levels change on the falling CLOCK edge, well below half the CLOCK rate
// Notes:   all three freeze while RUN is low, like a stopped oscillator
`timescale 1ns/1ps
module osc_model (
   input  wire logic CLOCK,     // system clock
   input  wire logic RUN,       // oscillators running
   output logic      FAST_OSC,  // period 4 cycles
   output logic      SLOW_OSC,  // period 6 cycles
   output logic      SLOW_XTAL  // period 8 cycles
);
   int ph = 0;

   // a stopped source must give no ticks at all
   always @(negedge CLOCK) begin
      if (RUN) begin
         ph <= ph + 1;
      end
   end

   assign FAST_OSC  = (ph % 4) < 2;
   assign SLOW_OSC  = (ph % 6) < 3;
   assign SLOW_XTAL = (ph % 8) < 4;
endmodule

// [bench/testbench.sv]
// Purpose: self-checking bench of the keyed watchdog
// Assumes: source 01 ticks every CLOCK, so those timeouts are exact
// Notes:   oscillator sources are checked with one period of slack
`timescale 1ns/1ps
`include "keyed_watchdog_cfg.svh"
module testbench;
   import keyed_watchdog_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        run   = 1'b0;
   reg_req_s    req   = '0;
   logic [31:0] rdata;
   logic        reset_req;
   logic        irq;
   logic        fast;
   logic        slow;
   logic        xtal;
   int          err_total = 0;
   int          total_checks = 0;
   int          cyc = 0;
   logic [15:0] lfsr = 16'hc996;

   keyed_watchdog_timer dut (.CLOCK(clock), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
      .FAST_OSC(fast), .SLOW_OSC(slow), .SLOW_XTAL(xtal), .RESET_REQ(reset_req),
      .TIMEOUT_IRQ(irq));
   osc_model osc (.CLOCK(clock), .RUN(run), .FAST_OSC(fast), .SLOW_OSC(slow),
      .SLOW_XTAL(xtal));

   initial begin
      forever #2.5 clock = ~clock;
   end

   function logic [15:0] next_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // cycles from the write edge to the visible timeout, source 01
   function int t_exp(input int c);
      return (c + 1) * 128;
   endfunction
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(negedge clock);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clock);
      req.wr = 1'b0;
   endtask
   task automatic kwr(input logic [3:0] a, input logic [15:0] d);
      wr(a, {`WDT_KEY_VALUE, d});
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(negedge clock);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(negedge clock);
      req.rd = 1'b0;
      chk(rdata, exp);
   endtask
   // counts cycles until either timeout output shows, or the limit
   task automatic meas(input int lim, output int n);
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (n < lim && reset_req !== 1'b1 && irq !== 1'b1);
   endtask

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         report_and_stop();
      end
   end

   initial begin
      int n;
      int p;
      logic [7:0] v;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      rd(`WDT_OFF_CONFIG, 32'h0);
      rd(`WDT_OFF_CLKSRC, 32'h0);
      rd(`WDT_OFF_CONST, 32'h0000_00ff);
      rd(`WDT_OFF_FEED, 32'h0);
      v = 8'hff;
      for (int i = 0; i < 6; i++) begin
         lfsr = next_rand(lfsr);
         wr(`WDT_OFF_CONST, {lfsr[15:1], 1'b1, 8'h00, lfsr[15:8]});
         rd(`WDT_OFF_CONST, {24'h0, v});
         v = lfsr[7:0];
         kwr(`WDT_OFF_CONST, {8'h00, v});
         rd(`WDT_OFF_CONST, {24'h0, v});
      end
      rd(4'h2, 32'h0);
      $display("test registers done");
      kwr(`WDT_OFF_CLKSRC, 16'h1);
      kwr(`WDT_OFF_CONFIG, 16'h1);
      meas(40000, n);
      chk(32'(n), 32'(t_exp(v)));
      chk({reset_req, irq}, 2'b10);
      $display("test reset timeout done");
      kwr(`WDT_OFF_CONFIG, 16'h0);
      kwr(`WDT_OFF_CONST, 16'h1);
      kwr(`WDT_OFF_CONFIG, 16'h1);
      kwr(`WDT_OFF_FEED, 16'h1234);
      wr(`WDT_OFF_FEED, 32'h0000_55aa);
      meas(1000, n);
      chk(32'(n), 32'(t_exp(1) - 4));
      repeat (200) @(negedge clock);
      kwr(`WDT_OFF_FEED, `WATCHDOG_FEED_VALUE);
      meas(1000, n);
      chk(32'(n), 32'(t_exp(1)));
      $display("test feed done");
      kwr(`WDT_OFF_CONFIG, 16'h0);
      kwr(`WDT_OFF_CONST, 16'h0);
      kwr(`WDT_OFF_CONFIG, 16'h3);
      meas(1000, n);
      chk(32'(n), 32'(t_exp(0)));
      chk({reset_req, irq}, 2'b01);
      rd(`WDT_OFF_CONFIG, 32'h7);
      kwr(`WDT_OFF_CONFIG, 16'h5);
      chk(irq, 1'b0);
      meas(200, n);
      chk({reset_req, irq}, 2'b10);
      rd(`WDT_OFF_CONFIG, 32'h1);
      kwr(`WDT_OFF_CONFIG, 16'h3);
      meas(200, n);
      chk(irq, 1'b1);
      kwr(`WDT_OFF_FEED, `WATCHDOG_FEED_VALUE);
      kwr(`WDT_OFF_CONFIG, 16'h3);
      chk(irq, 1'b0);
      rd(`WDT_OFF_CONFIG, 32'h3);
      $display("test interrupt done");
      kwr(`WDT_OFF_CONFIG, 16'h0);
      kwr(`WDT_OFF_CLKSRC, 16'h2);
      kwr(`WDT_OFF_CONFIG, 16'h1);
      meas(1500, n);
      chk(32'(n), 32'd1500);
      rd(`WDT_OFF_CLKSRC, 32'h2);
      run = 1'b1;
      for (int s = 0; s < 4; s++) begin
         if (s != 1) begin
            p = (s == 0) ? 4 : (s == 2) ? 6 : 8;
            kwr(`WDT_OFF_CONFIG, 16'h0);
            kwr(`WDT_OFF_CLKSRC, 16'(s));
            kwr(`WDT_OFF_CONFIG, 16'h1);
            meas(2000, n);
            chk(32'(n > 127 * p && n <= 128 * p), 32'h1);
         end
      end
      $display("test sources done");
      report_and_stop();
   end
endmodule
